/* pc_stack_and_table_read.sv */
// program counter, return-address stack control, interrupt acknowledge and table reads
// assumes the sequencer issues at most one command per cycle and only while busy_o is low;
// program memory returns table data in the same cycle as prog_rd_o
//
// Notes on behaviour
// - calls and interrupt acknowledges push the current program counter
// - sub_return and irq_return reload the program counter from the stack top
// - stack and its pointer have no software access path at all
// - any reset points the stack pointer at level 0, the bottom of the empty stack
// - full stack: enabled interrupt stays pending, acknowledge withheld, no push
// - once a return leaves the full condition, the pending interrupt is acknowledged
// - a call while full is not blocked; the push overflows the stack
// - on overflow the oldest saved address is overwritten and lost
// - after reset execution starts at program address zero
// - program words are 16 bits; depth ranges from 8K to 64K words
// - table address combines the low and high table pointers
// - a table read writes the low byte into the named data register
// - the high byte goes to table_high_latch; unused bits read zero
// - basic table reads reach sector 0 only; others need table_read_ext
// - for table_read_page the low pointer is an offset in the high-pointer page
// - every table instruction not refused by the sector check takes two instruction cycles
// - software can read and write table_high_latch
// - each ALU result updates carry, zero, sign and overflow status
// - a pc_low_register write stays in the page and costs a dummy cycle
module pc_stack_and_table_read (
   input wire logic clock_i,
   input wire logic rst_i,
   // sequencer commands
   input wire logic step_i,
   input wire logic jump_i,
   input wire logic [pc_flow_pkg::PM_ADDR_W-1:0] jump_target_i,
   input wire logic call_i,
   input wire logic [pc_flow_pkg::PM_ADDR_W-1:0] call_target_i,
   input wire logic sub_return_i,
   input wire logic irq_return_i,
   input wire logic pc_low_wr_i,
   input wire logic [pc_flow_pkg::BYTE_W-1:0] pc_low_data_i,

   // interrupt logic
   input wire logic irq_req_i,
   input wire logic irq_enable_i,
   input wire logic [pc_flow_pkg::PM_ADDR_W-1:0] irq_vector_i,

   // table reads
   input wire logic table_read_i,
   input wire logic table_read_page_i,
   input wire logic table_read_ext_i,
   input wire logic [pc_flow_pkg::SECTOR_W-1:0] table_dest_sector_i,
   input wire logic [pc_flow_pkg::DATA_OFS_W-1:0] table_dest_ofs_i,
   input wire logic [pc_flow_pkg::BYTE_W-1:0] table_ptr_low_i,
   input wire logic [pc_flow_pkg::BYTE_W-1:0] table_ptr_high_i,
   input wire logic [pc_flow_pkg::PM_WORD_W-1:0] prog_data_i,
   input wire logic table_high_latch_wr_i,
   input wire logic [pc_flow_pkg::BYTE_W-1:0] table_high_latch_data_i,

   // ALU results
   input wire logic alu_valid_i,
   input wire logic alu_carry_i,
   input wire logic alu_zero_i,
   input wire logic alu_neg_i,
   input wire logic alu_ovf_i,

   // outputs
   output logic [pc_flow_pkg::PM_ADDR_W-1:0] pc_o,
   output logic busy_o,
   output logic irq_ack_o,
   output logic irq_pending_o,
   output logic stack_full_o,
   output logic [pc_flow_pkg::PM_ADDR_W-1:0] prog_addr_o,
   output logic prog_rd_o,
   output logic data_wr_o,
   output logic [pc_flow_pkg::SECTOR_W-1:0] data_wr_sector_o,
   output logic [pc_flow_pkg::DATA_OFS_W-1:0] data_wr_ofs_o,
   output logic [pc_flow_pkg::BYTE_W-1:0] data_wr_data_o,
   output logic table_fault_o,
   output logic [pc_flow_pkg::BYTE_W-1:0] table_high_latch_o,
   output logic [pc_flow_pkg::STATUS_W-1:0] status_o
);

   pc_flow_pkg::flow_state_t state_q;
   pc_flow_pkg::flow_state_t state_d;

   logic [pc_flow_pkg::PM_ADDR_W-1:0] pc_q;
   logic [pc_flow_pkg::PM_ADDR_W-1:0] pc_d;
   logic busy_q;
   logic irq_pending_q;
   logic irq_ack_q;

   logic [pc_flow_pkg::PM_ADDR_W-1:0] prog_addr_q;
   logic prog_rd_q;

   logic data_wr_q;
   logic [pc_flow_pkg::SECTOR_W-1:0] data_wr_sector_q;
   logic [pc_flow_pkg::DATA_OFS_W-1:0] data_wr_ofs_q;
   logic [pc_flow_pkg::BYTE_W-1:0] data_wr_data_q;
   logic [pc_flow_pkg::SECTOR_W-1:0] dest_sector_q;
   logic [pc_flow_pkg::DATA_OFS_W-1:0] dest_ofs_q;

   logic table_fault_q;
   logic [pc_flow_pkg::STATUS_W-1:0] status_q;

   logic stack_full;
   logic [pc_flow_pkg::PM_ADDR_W-1:0] stack_top;
   logic [pc_flow_pkg::PM_ADDR_W-1:0] table_addr;
   logic running;
   logic any_return;
   logic any_table;
   logic table_ok;
   logic take_irq;
   logic push;
   logic pop;
   logic capture;

   // basic forms may only target the first data sector
   function automatic logic table_dest_allowed(
      input logic ext,
      input logic [pc_flow_pkg::SECTOR_W-1:0] sector
   );
      table_dest_allowed = ext || (sector == pc_flow_pkg::BASIC_TABLE_SECTOR);
   endfunction

   assign running = (state_q == pc_flow_pkg::ST_RUN);
   assign any_return = running && (sub_return_i || irq_return_i);
   assign any_table = running
      && (table_read_i || table_read_page_i || table_read_ext_i);
   assign table_ok = any_table
      && table_dest_allowed(table_read_ext_i, table_dest_sector_i);

   // a branch-type command outranks a table read and an acknowledge
   function automatic logic branch_request(
      input logic call,
      input logic jump,
      input logic ret,
      input logic pc_low_register
   );
      branch_request = call || jump || ret || pc_low_register;
   endfunction

   // acknowledge only in an idle run cycle with room on the stack
   assign take_irq = running && irq_pending_q && !stack_full
      && !any_table
      && !branch_request(call_i, jump_i, any_return, pc_low_wr_i);

   assign push = (running && call_i) || take_irq;
   // a call or jump in the same cycle drops the return
   assign pop = any_return && !call_i && !jump_i;
   assign capture = (state_q == pc_flow_pkg::ST_TABLE);

   return_stack #(
      .LEVELS(pc_flow_pkg::STACK_LEVELS),
      .WIDTH(pc_flow_pkg::PM_ADDR_W)
   ) u_stack (
      .clock_i(clock_i),
      .rst_i(rst_i),
      .push_i(push),
      .push_data_i(pc_q),
      .pop_i(pop),
      .top_o(stack_top),
      .full_o(stack_full)
   );

   table_read_path u_table (
      .clock_i(clock_i),
      .rst_i(rst_i),
      .ptr_low_i(table_ptr_low_i),
      .ptr_high_i(table_ptr_high_i),
      .addr_o(table_addr),
      .capture_i(capture),
      .word_i(prog_data_i),
      .latch_wr_i(table_high_latch_wr_i),
      .latch_wr_data_i(table_high_latch_data_i),
      .latch_o(table_high_latch_o)
   );

   // next program counter and next state
   always_comb begin
      pc_d = pc_q;
      state_d = state_q;
      case (state_q)
         pc_flow_pkg::ST_RUN: begin
            if (call_i) begin
               pc_d = call_target_i;
               state_d = pc_flow_pkg::ST_BRANCH;
            end else if (jump_i) begin
               pc_d = jump_target_i;
               state_d = pc_flow_pkg::ST_BRANCH;
            end else if (sub_return_i || irq_return_i) begin
               pc_d = stack_top;
               state_d = pc_flow_pkg::ST_BRANCH;
            end else if (pc_low_wr_i) begin
               pc_d = {pc_q[pc_flow_pkg::PM_ADDR_W-1:pc_flow_pkg::PAGE_W], pc_low_data_i};
               state_d = pc_flow_pkg::ST_BRANCH;
            end else if (table_ok) begin
               pc_d = pc_q;
               state_d = pc_flow_pkg::ST_TABLE;
            end else if (take_irq) begin
               pc_d = irq_vector_i;
               state_d = pc_flow_pkg::ST_BRANCH;
            end else if (step_i) begin
               pc_d = pc_q + 1'b1;
            end
         end
         pc_flow_pkg::ST_BRANCH: begin
            state_d = pc_flow_pkg::ST_RUN;
         end
         pc_flow_pkg::ST_TABLE: begin
            pc_d = pc_q + 1'b1;
            state_d = pc_flow_pkg::ST_RUN;
         end
         default: begin
            state_d = pc_flow_pkg::ST_RUN;
         end
      endcase
   end

   always_ff @(posedge clock_i) begin
      if (rst_i) begin
         state_q <= pc_flow_pkg::ST_RUN;
      end else begin
         state_q <= state_d;
      end
   end

   always_ff @(posedge clock_i) begin
      if (rst_i) begin
         pc_q <= pc_flow_pkg::RESET_VECTOR;
      end else begin
         pc_q <= pc_d;
      end
   end

   // busy covers the dummy cycle and the second table cycle
   always_ff @(posedge clock_i) begin
      if (rst_i) begin
         busy_q <= 1'b0;
      end else begin
         busy_q <= (state_d != pc_flow_pkg::ST_RUN);
      end
   end

   // pending request: a new request wins over the acknowledge clear
   always_ff @(posedge clock_i) begin
      if (rst_i) begin
         irq_pending_q <= 1'b0;
      end else if (irq_req_i && irq_enable_i) begin
         irq_pending_q <= 1'b1;
      end else if (take_irq) begin
         irq_pending_q <= 1'b0;
      end
   end

   always_ff @(posedge clock_i) begin
      if (rst_i) begin
         irq_ack_q <= 1'b0;
      end else begin
         irq_ack_q <= take_irq;
      end
   end

   // first table cycle: strobe program memory
   always_ff @(posedge clock_i) begin
      if (rst_i) begin
         prog_rd_q <= 1'b0;
      end else begin
         prog_rd_q <= table_ok
            && !branch_request(call_i, jump_i, any_return, pc_low_wr_i);
      end
   end

   // address and destination held through the second cycle
   always_ff @(posedge clock_i) begin
      if (rst_i) begin
         prog_addr_q <= pc_flow_pkg::RESET_VECTOR;
         dest_sector_q <= '0;
         dest_ofs_q <= '0;
      end else if (table_ok) begin
         prog_addr_q <= table_addr;
         dest_sector_q <= table_dest_sector_i;
         dest_ofs_q <= table_dest_ofs_i;
      end
   end

   // basic form aimed outside the first sector is refused
   always_ff @(posedge clock_i) begin
      if (rst_i) begin
         table_fault_q <= 1'b0;
      end else begin
         table_fault_q <= any_table && !table_ok;
      end
   end

   // second table cycle: one-cycle write strobe
   always_ff @(posedge clock_i) begin
      if (rst_i) begin
         data_wr_q <= 1'b0;
      end else begin
         data_wr_q <= capture;
      end
   end

   // low byte and destination held until the next table read
   always_ff @(posedge clock_i) begin
      if (rst_i) begin
         data_wr_sector_q <= '0;
         data_wr_ofs_q <= '0;
         data_wr_data_q <= '0;
      end else if (capture) begin
         data_wr_sector_q <= dest_sector_q;
         data_wr_ofs_q <= dest_ofs_q;
         data_wr_data_q <= prog_data_i[pc_flow_pkg::BYTE_W-1:0];
      end
   end

   // status flags follow every ALU result
   always_ff @(posedge clock_i) begin
      if (rst_i) begin
         status_q <= pc_flow_pkg::STATUS_RESET;
      end else if (alu_valid_i) begin
         status_q[pc_flow_pkg::STATUS_CARRY] <= alu_carry_i;
         status_q[pc_flow_pkg::STATUS_ZERO] <= alu_zero_i;
         status_q[pc_flow_pkg::STATUS_NEG] <= alu_neg_i;
         status_q[pc_flow_pkg::STATUS_OVF] <= alu_ovf_i;
      end
   end

   // stack contents and pointer never reach a port
   assign pc_o = pc_q;
   assign busy_o = busy_q;
   assign irq_ack_o = irq_ack_q;
   assign irq_pending_o = irq_pending_q;
   assign stack_full_o = stack_full;
   assign prog_addr_o = prog_addr_q;
   assign prog_rd_o = prog_rd_q;
   assign data_wr_o = data_wr_q;
   assign data_wr_sector_o = data_wr_sector_q;
   assign data_wr_ofs_o = data_wr_ofs_q;
   assign data_wr_data_o = data_wr_data_q;
   assign table_fault_o = table_fault_q;
   assign status_o = status_q;

endmodule

/* pc_flow_pkg.sv */
// constants, types and timing figures shared by the program-flow block
// assumes one instruction cycle per clock_i edge at 10 MHz
package pc_flow_pkg;

   // program memory: 16-bit words, depth from 8K up to 64K words
   localparam int PM_ADDR_W = 16;
   localparam int PM_ADDR_W_MIN = 13;
   localparam int PM_WORD_W = 16;
   localparam logic [15:0] PM_WORD_MASK = 16'hffff;
   localparam int BYTE_W = 8;
   localparam int PAGE_W = 8;

   // reset vector
   localparam logic [PM_ADDR_W-1:0] RESET_VECTOR = 16'h0000;

   // return-address stack depth, a power of two
   localparam int STACK_LEVELS = 8;

   // data memory destination: sector number and offset inside it
   localparam int SECTOR_W = 3;
   localparam int DATA_OFS_W = 8;
   localparam logic [SECTOR_W-1:0] BASIC_TABLE_SECTOR = 3'h0;

   // status register fields
   localparam int STATUS_W = 4;
   localparam int STATUS_CARRY = 0;
   localparam int STATUS_ZERO = 1;
   localparam int STATUS_NEG = 2;
   localparam int STATUS_OVF = 3;
   localparam logic [STATUS_W-1:0] STATUS_RESET = 4'h0;

   // instruction timing
   localparam int CLOCK_HZ = 10_000_000;
   localparam int TABLE_CYCLES = 2;
   localparam int BRANCH_CYCLES = 2;

   typedef enum logic [2:0] {
      ST_RUN = 3'b001,
      ST_BRANCH = 3'b010,
      ST_TABLE = 3'b100
   } flow_state_t;

endpackage

/* return_stack.sv */
// hidden return-address stack with wrap-around overflow
// assumes push and pop never arrive in the same cycle
module return_stack #(
   parameter int LEVELS = pc_flow_pkg::STACK_LEVELS,
   parameter int WIDTH = pc_flow_pkg::PM_ADDR_W
) (
   input wire logic clock_i,
   input wire logic rst_i,
   input wire logic push_i,
   input wire logic [WIDTH-1:0] push_data_i,
   input wire logic pop_i,
   output logic [WIDTH-1:0] top_o,
   output logic full_o
);
   localparam int PTR_W = $clog2(LEVELS);
   localparam logic [PTR_W:0] LEVELS_C = (PTR_W+1)'(LEVELS);
   localparam logic [PTR_W:0] ONE_C = (PTR_W+1)'(1);

   logic [WIDTH-1:0] level_q [LEVELS];
   logic [PTR_W-1:0] sp_q;
   logic [PTR_W:0] used_q;
   logic full_q;

   // storage holds only addresses, no reset needed
   always_ff @(posedge clock_i) begin
      if (push_i) begin
         level_q[sp_q] <= push_data_i;
      end
   end

   always_ff @(posedge clock_i) begin
      if (rst_i) begin
         sp_q <= '0;
         used_q <= '0;
         full_q <= 1'b0;
      end else if (push_i) begin
         sp_q <= sp_q + 1'b1;
         if (used_q != LEVELS_C) begin
            used_q <= used_q + 1'b1;
         end
         full_q <= (used_q + ONE_C) >= LEVELS_C;
      end else if (pop_i) begin
         sp_q <= sp_q - 1'b1;
         if (used_q != '0) begin
            used_q <= used_q - 1'b1;
         end
         full_q <= 1'b0;
      end
   end

   assign top_o = level_q[PTR_W'(sp_q - 1'b1)];
   assign full_o = full_q;

endmodule

/* table_read_path.sv */
// table pointer address forming and the high-byte latch
// assumes the latch is written either by software or by a read, never both at once
module table_read_path (
   input wire logic clock_i,
   input wire logic rst_i,
   input wire logic [pc_flow_pkg::BYTE_W-1:0] ptr_low_i,
   input wire logic [pc_flow_pkg::BYTE_W-1:0] ptr_high_i,
   output logic [pc_flow_pkg::PM_ADDR_W-1:0] addr_o,
   input wire logic capture_i,
   input wire logic [pc_flow_pkg::PM_WORD_W-1:0] word_i,
   input wire logic latch_wr_i,
   input wire logic [pc_flow_pkg::BYTE_W-1:0] latch_wr_data_i,
   output logic [pc_flow_pkg::BYTE_W-1:0] latch_o
);
   localparam logic [pc_flow_pkg::BYTE_W-1:0] HIGH_MASK =
      pc_flow_pkg::PM_WORD_MASK[pc_flow_pkg::PM_WORD_W-1:pc_flow_pkg::BYTE_W];

   logic [pc_flow_pkg::BYTE_W-1:0] latch_q;

   // page from the high pointer, offset from the low pointer
   function automatic logic [pc_flow_pkg::PM_ADDR_W-1:0] form_addr(
      input logic [pc_flow_pkg::BYTE_W-1:0] page,
      input logic [pc_flow_pkg::BYTE_W-1:0] offset
   );
      form_addr = {page, offset};
   endfunction

   assign addr_o = form_addr(ptr_high_i, ptr_low_i);

   always_ff @(posedge clock_i) begin
      if (rst_i) begin
         latch_q <= '0;
      end else if (capture_i) begin
         latch_q <= word_i[pc_flow_pkg::PM_WORD_W-1:pc_flow_pkg::BYTE_W] & HIGH_MASK;
      end else if (latch_wr_i) begin
         latch_q <= latch_wr_data_i;
      end
   end

   assign latch_o = latch_q;

endmodule

/* pc_flow_checker.sv */
// assertion checker for the program-flow block, bound to its top module
// assumes one clock domain with a synchronous active-high reset
module pc_flow_checker (
   input wire logic clock_i,
   input wire logic rst_i,
   input wire logic call_i,
   input wire logic [15:0] call_target_i,
   input wire logic sub_return_i,
   input wire logic irq_req_i,
   input wire logic irq_enable_i,
   input wire logic [15:0] irq_vector_i,
   input wire logic table_read_i,
   input wire logic [2:0] table_dest_sector_i,
   input wire logic [7:0] table_ptr_low_i,
   input wire logic [7:0] table_ptr_high_i,
   input wire logic [15:0] prog_data_i,
   input wire logic [15:0] pc_o,
   input wire logic busy_o,
   input wire logic irq_ack_o,
   input wire logic irq_pending_o,
   input wire logic stack_full_o,
   input wire logic [15:0] prog_addr_o,
   input wire logic prog_rd_o,
   input wire logic data_wr_o,
   input wire logic [7:0] data_wr_data_o,
   input wire logic table_fault_o,
   input wire logic [7:0] table_high_latch_o
);
   default clocking cb @(posedge clock_i); endclocking
   default disable iff (rst_i);

   property p_reset;
      disable iff (1'b0) rst_i |=> pc_o == 16'h0000 && !stack_full_o && !irq_pending_o;
   endproperty
   property p_call;
      !busy_o && call_i |=> busy_o && pc_o == $past(call_target_i);
   endproperty
   property p_full_no_ack;
      stack_full_o |=> !irq_ack_o;
   endproperty
   property p_pending;
      irq_req_i && irq_enable_i |=> irq_pending_o;
   endproperty
   property p_ack_vector;
      irq_ack_o |-> busy_o && pc_o == $past(irq_vector_i);
   endproperty
   property p_ack_after_return;
      irq_pending_o && $fell(stack_full_o) |-> ##[1:3] irq_ack_o;
   endproperty
   property p_table_addr;
      prog_rd_o |-> busy_o && prog_addr_o == {$past(table_ptr_high_i), $past(table_ptr_low_i)};
   endproperty
   property p_table_data;
      prog_rd_o |=> data_wr_o && !busy_o && data_wr_data_o == $past(prog_data_i[7:0])
         && table_high_latch_o == $past(prog_data_i[15:8]);
   endproperty
   property p_fault;
      !busy_o && table_read_i && table_dest_sector_i != 3'h0 && !call_i && !sub_return_i
         |=> table_fault_o && !prog_rd_o && !busy_o;
   endproperty

   a_reset: assert property (p_reset) else $error("reset state wrong");
   a_call: assert property (p_call) else $error("call not taken");
   a_full_no_ack: assert property (p_full_no_ack) else $error("ack while full");
   a_pending: assert property (p_pending) else $error("request not recorded");
   a_ack_vector: assert property (p_ack_vector) else $error("ack without vector");
   a_ack_after_return: assert property (p_ack_after_return) else $error("ack missing");
   a_table_addr: assert property (p_table_addr) else $error("table address wrong");
   a_table_data: assert property (p_table_data) else $error("table data wrong");
   a_fault: assert property (p_fault) else $error("sector check missing");

   c_full_pending: cover property (stack_full_o && irq_pending_o);
   c_ack: cover property (irq_ack_o);
   c_fault: cover property (table_fault_o);
endmodule

bind pc_stack_and_table_read pc_flow_checker u_pc_flow_checker (
   .clock_i(clock_i), .rst_i(rst_i), .call_i(call_i), .call_target_i(call_target_i),
   .sub_return_i(sub_return_i), .irq_req_i(irq_req_i), .irq_enable_i(irq_enable_i),
   .irq_vector_i(irq_vector_i), .table_read_i(table_read_i), .table_dest_sector_i(table_dest_sector_i),
   .table_ptr_low_i(table_ptr_low_i), .table_ptr_high_i(table_ptr_high_i), .prog_data_i(prog_data_i),
   .pc_o(pc_o), .busy_o(busy_o), .irq_ack_o(irq_ack_o), .irq_pending_o(irq_pending_o),
   .stack_full_o(stack_full_o), .prog_addr_o(prog_addr_o), .prog_rd_o(prog_rd_o), .data_wr_o(data_wr_o),
   .data_wr_data_o(data_wr_data_o), .table_fault_o(table_fault_o), .table_high_latch_o(table_high_latch_o)
);

/* prog_mem_model.sv */
// program memory stand-in answering table fetches
// assumes prog_rd_o is a one-cycle pulse with its address held meanwhile
module prog_mem_model (
   input wire logic clock_i,
   input wire logic rd_i,
   input wire logic [15:0] addr_i,
   output logic [15:0] word_o
);
   timeunit 1ns;
   timeprecision 1ns;
   logic junk_q = 1'b0;
   always_ff @(posedge clock_i) junk_q <= ~junk_q;
   // 16-bit words; outside a fetch the bus changes every cycle
   assign word_o = rd_i ? {addr_i[7:0] ^ 8'h5a, addr_i[15:8] ^ addr_i[7:0]} : {16{junk_q}} ^ 16'h3c3c;
endmodule

/* pc_stack_and_table_read_tb.sv */
// self-checking bench for the program-flow block with a reference model
// assumes the memory stand-in answers in the same cycle as prog_rd_o
module pc_stack_and_table_read_tb;
   timeunit 1ns;
   timeprecision 1ns;
   logic clock_i = 1'b0, rst_i = 1'b1, step_i = 1'b0, jump_i = 1'b0, call_i = 1'b0;
   logic sub_return_i = 1'b0, irq_return_i = 1'b0, pc_low_wr_i = 1'b0, irq_req_i = 1'b0, irq_enable_i = 1'b0;
   logic table_read_i = 1'b0, table_read_page_i = 1'b0, table_read_ext_i = 1'b0, table_high_latch_wr_i = 1'b0;
   logic alu_valid_i = 1'b0, alu_carry_i = 1'b0, alu_zero_i = 1'b0, alu_neg_i = 1'b0, alu_ovf_i = 1'b0;
   logic [15:0] jump_target_i = 16'h0000, call_target_i = 16'h0000, irq_vector_i = 16'h0a40;
   logic [7:0] pc_low_data_i = 8'h00, table_ptr_low_i = 8'h00, table_ptr_high_i = 8'h00;
   logic [7:0] table_dest_ofs_i = 8'h00, table_high_latch_data_i = 8'h00;
   logic [2:0] table_dest_sector_i = 3'h0;
   logic [15:0] prog_data_i, pc_o, prog_addr_o;
   logic busy_o, irq_ack_o, irq_pending_o, stack_full_o, prog_rd_o, data_wr_o, table_fault_o;
   logic [2:0] data_wr_sector_o;
   logic [7:0] data_wr_ofs_o, data_wr_data_o, table_high_latch_o;
   logic [3:0] status_o, f;
   int mismatches = 0, n_compared = 0, i, k;
   logic [15:0] pc_m, w, e;
   logic [15:0] stk[$];

   always #50 clock_i = ~clock_i;

   pc_stack_and_table_read u_pc_stack_and_table_read (
      .clock_i(clock_i), .rst_i(rst_i), .step_i(step_i), .jump_i(jump_i), .jump_target_i(jump_target_i),
      .call_i(call_i), .call_target_i(call_target_i), .sub_return_i(sub_return_i), .irq_return_i(irq_return_i),
      .pc_low_wr_i(pc_low_wr_i), .pc_low_data_i(pc_low_data_i), .irq_req_i(irq_req_i),
      .irq_enable_i(irq_enable_i), .irq_vector_i(irq_vector_i), .table_read_i(table_read_i),
      .table_read_page_i(table_read_page_i), .table_read_ext_i(table_read_ext_i),
      .table_dest_sector_i(table_dest_sector_i), .table_dest_ofs_i(table_dest_ofs_i),
      .table_ptr_low_i(table_ptr_low_i), .table_ptr_high_i(table_ptr_high_i), .prog_data_i(prog_data_i),
      .table_high_latch_wr_i(table_high_latch_wr_i), .table_high_latch_data_i(table_high_latch_data_i),
      .alu_valid_i(alu_valid_i), .alu_carry_i(alu_carry_i), .alu_zero_i(alu_zero_i), .alu_neg_i(alu_neg_i),
      .alu_ovf_i(alu_ovf_i), .pc_o(pc_o), .busy_o(busy_o), .irq_ack_o(irq_ack_o),
      .irq_pending_o(irq_pending_o), .stack_full_o(stack_full_o), .prog_addr_o(prog_addr_o),
      .prog_rd_o(prog_rd_o), .data_wr_o(data_wr_o), .data_wr_sector_o(data_wr_sector_o),
      .data_wr_ofs_o(data_wr_ofs_o), .data_wr_data_o(data_wr_data_o), .table_fault_o(table_fault_o),
      .table_high_latch_o(table_high_latch_o), .status_o(status_o)
   );
   prog_mem_model u_prog_mem_model (.clock_i(clock_i), .rd_i(prog_rd_o), .addr_i(prog_addr_o), .word_o(prog_data_i));

   task tally_and_finish;
      $display("compared %0d mismatches %0d", n_compared, mismatches);
      if (mismatches == 0 && n_compared > 0) $display("bench passed");
      else $display("bench failed");
      $finish;
   endtask
   task chk(input string m, input logic [15:0] got, input logic [15:0] exp);
      n_compared++;
      if (got !== exp) begin
         mismatches++;
         $display("BAD %0t %s got %h exp %h", $time, m, got, exp);
      end
   endtask
   task tick;
      @(posedge clock_i);
      @(negedge clock_i);
   endtask
   task call(input logic [15:0] t);
      call_i = 1'b1;
      call_target_i = t;
      tick;
      call_i = 1'b0;
      if (stk.size() == 8) void'(stk.pop_front());
      stk.push_back(pc_m);
      pc_m = t;
      chk("call", pc_o, pc_m);
      chk("call busy", busy_o, 1'b1);
      tick;
   endtask
   task ret(input logic irq);
      sub_return_i = ~irq;
      irq_return_i = irq;
      tick;
      sub_return_i = 1'b0;
      irq_return_i = 1'b0;
      pc_m = stk.pop_back();
      chk("return", pc_o, pc_m);
      tick;
   endtask

   initial begin
      repeat (20000) @(posedge clock_i);
      mismatches++;
      tally_and_finish;
   end

   initial begin
      void'($urandom(10923));
      repeat (2) @(posedge clock_i);
      @(negedge clock_i);
      rst_i = 1'b0;
      pc_m = 16'h0000;
      chk("reset pc", pc_o, pc_m);
      chk("reset full", stack_full_o, 1'b0);
      $display("test reset done");
      irq_enable_i = 1'b1;
      for (i = 0; i < 8; i++) begin
         step_i = 1'b1;
         tick;
         step_i = 1'b0;
         pc_m++;
         chk("step", pc_o, pc_m);
         call(16'($urandom));
      end
      chk("full", stack_full_o, 1'b1);
      irq_req_i = 1'b1;
      tick;
      irq_req_i = 1'b0;
      for (i = 0; i < 3; i++) begin
         chk("pending", irq_pending_o, 1'b1);
         chk("no ack", irq_ack_o, 1'b0);
         tick;
      end
      call(16'h0b6d);
      ret(1'b0);
      chk("not full", stack_full_o, 1'b0);
      for (k = 0; k < 4 && irq_ack_o !== 1'b1; k++) tick;
      if (irq_ack_o !== 1'b1) begin
         mismatches++;
         tally_and_finish;
      end
      stk.push_back(pc_m);
      pc_m = irq_vector_i;
      chk("ack pc", pc_o, pc_m);
      tick;
      chk("ack pulse", irq_ack_o, 1'b0);
      ret(1'b1);
      for (i = 0; i < 7; i++) ret(1'b0);
      $display("test stack done");
      irq_enable_i = 1'b0;
      for (i = 0; i < 12; i++) begin
         k = i % 3;
         table_ptr_low_i = 8'($urandom);
         table_ptr_high_i = 8'($urandom);
         table_dest_ofs_i = 8'($urandom);
         table_dest_sector_i = (k == 2) ? 3'(1 + $urandom % 7) : 3'h0;
         table_read_i = (k == 0);
         table_read_page_i = (k == 1);
         table_read_ext_i = (k == 2);
         w = {table_ptr_high_i, table_ptr_low_i};
         e = {w[7:0] ^ 8'h5a, w[15:8] ^ w[7:0]};
         tick;
         {table_read_i, table_read_page_i, table_read_ext_i} = 3'b000;
         chk("fetch addr", prog_addr_o, w);
         chk("fetch busy", busy_o, 1'b1);
         chk("fetch strobe", prog_rd_o, 1'b1);
         tick;
         pc_m++;
         chk("low byte", data_wr_data_o, e[7:0]);
         chk("write strobe", data_wr_o, 1'b1);
         chk("latch", table_high_latch_o, e[15:8]);
         chk("dest", {data_wr_sector_o, data_wr_ofs_o}, {table_dest_sector_i, table_dest_ofs_i});
         chk("table pc", pc_o, pc_m);
      end
      jump_i = 1'b1;
      jump_target_i = 16'h12f0;
      tick;
      jump_i = 1'b0;
      chk("jump", pc_o, 16'h12f0);
      tick;
      pc_low_wr_i = 1'b1;
      pc_low_data_i = 8'h0c;
      tick;
      pc_low_wr_i = 1'b0;
      chk("page jump", pc_o, 16'h120c);
      chk("dummy cycle", busy_o, 1'b1);
      tick;
      table_read_i = 1'b1;
      table_dest_sector_i = 3'h5;
      tick;
      table_read_i = 1'b0;
      chk("refused", table_fault_o, 1'b1);
      chk("no fetch", prog_rd_o, 1'b0);
      $display("test table done");
      table_high_latch_wr_i = 1'b1;
      alu_valid_i = 1'b1;
      for (i = 0; i < 8; i++) begin
         table_high_latch_data_i = 8'($urandom);
         f = 4'($urandom);
         {alu_ovf_i, alu_neg_i, alu_zero_i, alu_carry_i} = f;
         tick;
         chk("latch write", table_high_latch_o, table_high_latch_data_i);
         chk("status", status_o, f);
      end
      {table_high_latch_wr_i, alu_valid_i} = 2'b00;
      $display("test latch and status done");
      tally_and_finish;
   end
endmodule
